// file: src/ldt_pkg.sv
// Shared constants and types for the loop transceiver power-down and burst block.
// Assumes a 40 MHz core clock and 32-bit APB data.
package ldt_pkg;

  // clock and line timing
  localparam int CLK_KHZ         = 40000;
  localparam int CARRIER_KHZ     = 256;
  localparam int HALF_CYC        = CLK_KHZ / (2 * CARRIER_KHZ);
  localparam int REPLY_PERIODS   = 4;
  localparam int REPLY_CYC       = REPLY_PERIODS * CLK_KHZ / CARRIER_KHZ;
  localparam int NO_BURST_US     = 250;
  localparam int FRAME_US        = 125;
  localparam int NO_BURST_CYC    = NO_BURST_US * CLK_KHZ / 1000;
  localparam int FRAME_CYC       = FRAME_US * CLK_KHZ / 1000;

  localparam logic [6:0] HALF_LAST  = 7'(HALF_CYC - 1);
  localparam logic [9:0] REPLY_LAST = 10'(REPLY_CYC - 1);
  localparam logic [4:0] SEG_LAST   = 5'h15;
  localparam logic [1:0] MISS_LAST  = 2'h2;

  // register map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_VOICE  = 8'h08;
  localparam int         CTRL_EN_BIT    = 0;
  localparam int         CTRL_SLAVE_BIT = 1;
  localparam logic [1:0] CTRL_RESET     = 2'h0;

  typedef enum logic [1:0] {
    LDT_PWR_DOWN = 2'b00,
    LDT_PWR_WAIT = 2'b01,
    LDT_PWR_UP   = 2'b10
  } ldt_pwr_e;

  // ten-bit burst payload, sent voice msb first then the two signalling bits
  typedef struct packed {
    logic [7:0] voice;
    logic       sig_first;
    logic       sig_second;
  } ldt_burst_s;

endpackage : ldt_pkg

// file: src/ldt_tick.sv
// Cycle timer giving a one-cycle tick every PERIOD cycles while running.
// Assumes clear and run come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ldt_tick #(
  parameter int PERIOD = 10000
) (
  input  wire logic clk_i,   // core clock
  input  wire logic rst_i,   // sync reset, high
  input  wire logic clear_i, // restart count
  input  wire logic run_i,   // count enable
  output logic      tick_o   // one-cycle pulse
);
  logic [13:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i || !run_i) begin
      cnt_q  <= 14'h0000;
      tick_o <= 1'b0;
    end else if (cnt_q == 14'(PERIOD - 1)) begin
      cnt_q  <= 14'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 14'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule : ldt_tick
`default_nettype wire

// file: src/ldt_mod.sv
// Modified differential phase modulator for one ten-bit burst.
// Assumes start is only raised while busy is low.
`timescale 1ns/1ps
`default_nettype none
module ldt_mod
  import ldt_pkg::*;
(
  input  wire logic       clk_i,   // core clock
  input  wire logic       rst_i,   // sync reset, high
  input  wire logic       start_i, // begin a burst
  input  wire ldt_burst_s word_i,  // payload
  output logic            busy_o,  // burst in progress
  output logic            level_o, // line polarity
  output logic            drive_o  // low: line parked at reference
);
  logic [6:0] half_q;
  logic [4:0] seg_q;
  logic [9:0] shift_q;

  // segment 0 and 21 are the framing half cycles; bits use segments 1..20
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o  <= 1'b0;
      level_o <= 1'b0;
      drive_o <= 1'b0;
      half_q  <= 7'h00;
      seg_q   <= 5'h00;
      shift_q <= 10'h000;
    end else if (start_i && !busy_o) begin
      busy_o  <= 1'b1;
      level_o <= 1'b1;
      drive_o <= 1'b1;
      half_q  <= 7'h00;
      seg_q   <= 5'h00;
      shift_q <= word_i;
    end else if (busy_o) begin
      if (half_q != HALF_LAST) begin
        half_q <= half_q + 7'h01;
      end else begin
        half_q <= 7'h00;
        if (seg_q == SEG_LAST) begin
          busy_o  <= 1'b0;
          level_o <= 1'b0;
          drive_o <= 1'b0;
        end else begin
          seg_q <= seg_q + 5'h01;
          // a zero holds polarity over the boundary: one 128 kHz half cycle
          if (!seg_q[0] && seg_q != 5'h14) begin
            if (shift_q[9]) begin
              level_o <= ~level_o;
            end
            shift_q <= {shift_q[8:0], 1'b0};
          end else begin
            level_o <= ~level_o;
          end
        end
      end
    end
  end

  AST_MOD_OPEN: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_i && !busy_o) |=> (drive_o && level_o && busy_o))
    else $error("burst did not open with a driven half cycle");
endmodule : ldt_mod
`default_nettype wire

// file: src/ldt_top.sv
// Power-down sequencing and burst launch for a master or slave loop transceiver.
// Assumes a demodulator front end on this clock that pulses rx_done_i with the word,
// and an APB master on clk_i. Frame sync, signalling and power-down pins are synchronised here; the voice window is not.
// Functional notes
// - master with power-down low never modulates; demod and outputs stay alive.
// - master powered down updates signal outputs and valid flag at demod end.
// - valid flag holds until three frame edges without burst; signal outputs hold until next burst.
// - after power-up master waits three frame edges or edge after a burst.
// - first master burst uses last captured voice and signals at current edge.
// - slave power-down pin is weakly driven; external level wins.
// - slave with pin low only demodulates and outputs; no transmission.
// - powered slave replies to every master burst.
// - slave free-runs a 125 us frame after 250 us without master burst.
// - free-running slave bursts every second frame with fresh data.
// - slave pulls pin high on master burst, low after 250 us silence.
// - zero is a phase reversal of the 256 kHz carrier; one continues.
// - no preamble or start bits before the burst data.
// - each reversal is a single 128 kHz half cycle.
// - bursts begin and end with one 256 kHz half cycle.
// - burst carries eight voice and two signalling bits, half duplex.
// - slave reply starts four bit periods after demodulation ends.
`timescale 1ns/1ps
`default_nettype none
module ldt_top
  import ldt_pkg::*;
#(
  parameter int NO_BURST_LEN = NO_BURST_CYC, // silence before fallback
  parameter int FRAME_LEN    = FRAME_CYC     // free-running frame
) (
  input  wire logic       clk_i,                     // 40 MHz clock
  input  wire logic       rst_i,                     // sync reset, high
  input  wire logic [7:0] paddr_i,                   // apb address
  input  wire logic       psel_i,                    // apb select
  input  wire logic       penable_i,                 // apb enable
  input  wire logic       pwrite_i,                  // apb direction
  input  wire logic [31:0] pwdata_i,                 // apb write data
  output logic [31:0]     prdata_o,                  // apb read data
  output logic            pready_o,                  // apb ready
  output logic            pslverr_o,                 // apb error
  input  wire logic       frame_sync_input_i,        // frame sync pin
  input  wire logic       signal_in_first_i,         // signalling pin 1
  input  wire logic       signal_in_second_i,        // signalling pin 2
  input  wire logic [7:0] voice_word_i,              // voice from serial port
  input  wire logic       voice_capture_window_i,    // voice load window
  input  wire logic       rx_done_i,                 // demod end pulse
  input  wire ldt_burst_s rx_word_i,                 // demodulated word
  input  wire logic       low_power_select_n_i,      // power-down pin level
  output logic            low_power_select_n_o,      // weak drive value
  output logic            low_power_select_n_oe_o,   // weak drive enable
  output logic            signal_out_first_o,        // signalling out 1
  output logic            signal_out_second_o,       // signalling out 2
  output logic            burst_valid_flag_o,        // valid data flag
  output logic [7:0]      voice_out_o,               // received voice
  output logic            line_level_o,              // line polarity
  output logic            line_drive_o               // line driven
);

  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic       fs_last_q;
  logic       pd_last_q;
  logic       win_last_q;
  logic [1:0] ctrl_q;
  ldt_pwr_e   pwr_q;
  logic [1:0] wait_cnt_q;
  logic       wait_seen_q;
  logic [1:0] miss_cnt_q;
  ldt_burst_s rxbuf_q;
  logic       rx_frame_q;
  logic [7:0] voice_q;
  logic       reply_arm_q;
  logic [9:0] reply_cnt_q;
  logic       free_run_q;
  logic       odd_q;
  logic       sig1_q;
  logic       sig2_q;
  logic       tx_busy;
  logic       mod_level;
  logic       mod_drive;
  logic       nob_tick;
  logic       frm_tick;
  logic       fs_edge;
  logic       pd_lvl;
  logic       pd_rise;
  logic       en;
  logic       slave;
  logic       m_start;
  logic       s_start;
  logic       tx_start;
  ldt_burst_s tx_word;

  // two-flop synchronisers for pin inputs
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= (gi == 0) ? frame_sync_input_i :
                        (gi == 1) ? signal_in_first_i :
                        (gi == 2) ? signal_in_second_i : low_power_select_n_i;
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fs_last_q  <= 1'b0;
      pd_last_q  <= 1'b0;
      win_last_q <= 1'b0;
    end else begin
      fs_last_q  <= sync_q[0];
      pd_last_q  <= sync_q[3];
      win_last_q <= voice_capture_window_i;
    end
  end

  assign fs_edge = sync_q[0] && !fs_last_q;
  assign pd_lvl  = sync_q[3];
  assign pd_rise = sync_q[3] && !pd_last_q;
  assign en      = ctrl_q[CTRL_EN_BIT];
  assign slave   = ctrl_q[CTRL_SLAVE_BIT];

  // voice held at the close of each capture window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      voice_q <= 8'h00;
    end else if (win_last_q && !voice_capture_window_i) begin
      voice_q <= voice_word_i;
    end
  end

  // apb slave, zero wait: ready in the first access cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      ctrl_q    <= CTRL_RESET;
    end else begin
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      if (psel_i && !penable_i) begin
        case (paddr_i)
          ADDR_CTRL:   prdata_o <= {30'h0000_0000, ctrl_q};
          ADDR_STATUS: prdata_o <= {22'h00_0000, rx_frame_q, odd_q, free_run_q, tx_busy, burst_valid_flag_o,
                                    signal_out_first_o, signal_out_second_o, pd_lvl, pwr_q};
          ADDR_VOICE:  prdata_o <= {24'h00_0000, voice_out_o};
          default:     pslverr_o <= 1'b1;
        endcase
      end
      if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == ADDR_CTRL) begin
        ctrl_q <= pwdata_i[1:0];
      end
    end
  end

  // power state for both roles; slave skips the wait phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_q       <= LDT_PWR_DOWN;
      wait_cnt_q  <= 2'h0;
      wait_seen_q <= 1'b0;
    end else if (!pd_lvl || !en) begin
      pwr_q <= LDT_PWR_DOWN;
    end else begin
      case (pwr_q)
        LDT_PWR_DOWN: begin
          pwr_q       <= slave ? LDT_PWR_UP : LDT_PWR_WAIT;
          wait_cnt_q  <= 2'h0;
          wait_seen_q <= 1'b0;
        end
        LDT_PWR_WAIT: begin
          // three edges, or the edge after a demodulated burst
          if (fs_edge && (wait_seen_q || rx_done_i || wait_cnt_q == MISS_LAST)) begin
            pwr_q <= LDT_PWR_UP;
          end else if (fs_edge) begin
            wait_cnt_q <= wait_cnt_q + 2'h1;
          end
          if (rx_done_i) begin
            wait_seen_q <= 1'b1;
          end
        end
        LDT_PWR_UP:   pwr_q <= LDT_PWR_UP;
        default:      pwr_q <= LDT_PWR_DOWN;
      endcase
    end
  end

  // master modulates only once powered and past the wait
  assign m_start = !slave && en && fs_edge &&
                   ((pwr_q == LDT_PWR_UP) ||
                    (pwr_q == LDT_PWR_WAIT && (wait_seen_q || rx_done_i || wait_cnt_q == MISS_LAST)));
  // slave bursts only with its pin high
  assign s_start = slave && en && pd_lvl &&
                   ((reply_arm_q && reply_cnt_q == 10'h000) || (frm_tick && odd_q && !reply_arm_q));
  assign tx_start = (m_start || s_start) && !tx_busy;

  // payload: held voice, signalling sampled at the frame event
  always_comb begin
    tx_word.voice      = voice_q;
    tx_word.sig_first  = s_start ? sig1_q : sync_q[1];
    tx_word.sig_second = s_start ? sig2_q : sync_q[2];
  end

  // slave signalling sampled at demod end or internal frame edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sig1_q <= 1'b0;
      sig2_q <= 1'b0;
    end else if (rx_done_i || frm_tick) begin
      sig1_q <= sync_q[1];
      sig2_q <= sync_q[2];
    end
  end

  // received signalling and valid flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxbuf_q             <= '0;
      rx_frame_q          <= 1'b0;
      miss_cnt_q          <= 2'h0;
      signal_out_first_o  <= 1'b0;
      signal_out_second_o <= 1'b0;
      burst_valid_flag_o  <= 1'b0;
      voice_out_o         <= 8'h00;
    end else if (rx_done_i && (slave || pwr_q != LDT_PWR_UP)) begin
      // immediate update at demodulation end; restart miss count
      signal_out_first_o  <= rx_word_i.sig_first;
      signal_out_second_o <= rx_word_i.sig_second;
      burst_valid_flag_o  <= 1'b1;
      voice_out_o         <= rx_word_i.voice;
      miss_cnt_q          <= 2'h0;
      rx_frame_q          <= 1'b0;
    end else if (rx_done_i) begin
      rxbuf_q    <= rx_word_i;
      rx_frame_q <= 1'b1;
    end else if (!slave && fs_edge && pwr_q == LDT_PWR_UP) begin
      signal_out_first_o  <= rxbuf_q.sig_first;
      signal_out_second_o <= rxbuf_q.sig_second;
      voice_out_o         <= rxbuf_q.voice;
      burst_valid_flag_o  <= rx_frame_q;
      rx_frame_q          <= 1'b0;
    end else if (!slave && fs_edge) begin
      // hold until the third quiet frame edge
      if (miss_cnt_q == MISS_LAST) begin
        burst_valid_flag_o <= 1'b0;
      end else begin
        miss_cnt_q <= miss_cnt_q + 2'h1;
      end
    end
  end

  // reply four bit periods after master burst
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reply_arm_q <= 1'b0;
      reply_cnt_q <= 10'h000;
    end else if (slave && en && pd_lvl && rx_done_i) begin
      reply_arm_q <= 1'b1;
      reply_cnt_q <= REPLY_LAST;
    end else if (!pd_lvl || reply_cnt_q == 10'h000) begin
      reply_arm_q <= 1'b0;
    end else begin
      reply_cnt_q <= reply_cnt_q - 10'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      free_run_q <= 1'b0;
      odd_q      <= 1'b0;
    end else if (!slave || !en || !pd_lvl || rx_done_i) begin
      free_run_q <= 1'b0;
      odd_q      <= 1'b0;
    end else begin
      if (nob_tick) begin
        free_run_q <= 1'b1;
      end
      if (frm_tick) begin
        odd_q <= ~odd_q;
      end
    end
  end

  // weak pin drive: high on burst, low after silence; external level rules
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_power_select_n_o    <= 1'b0;
      low_power_select_n_oe_o <= 1'b0;
    end else begin
      low_power_select_n_oe_o <= slave && en;
      if (rx_done_i) begin
        low_power_select_n_o <= 1'b1;
      end else if (nob_tick) begin
        low_power_select_n_o <= 1'b0;
      end
    end
  end

  ldt_tick #(.PERIOD(NO_BURST_LEN)) u_nob (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (rx_done_i || pd_rise),
    .run_i   (slave && en),
    .tick_o  (nob_tick)
  );

  ldt_tick #(.PERIOD(FRAME_LEN)) u_frm (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (rx_done_i),
    .run_i   (free_run_q),
    .tick_o  (frm_tick)
  );

  ldt_mod u_mod (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (tx_start),
    .word_i  (tx_word),
    .busy_o  (tx_busy),
    .level_o (mod_level),
    .drive_o (mod_drive)
  );

  // mirror into top flops so ports come straight from registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_level_o <= 1'b0;
      line_drive_o <= 1'b0;
    end else begin
      line_level_o <= mod_level;
      line_drive_o <= mod_drive;
    end
  end

  AST_MASTER_PD_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
    (!slave && pwr_q == LDT_PWR_DOWN) |-> !tx_start)
    else $error("master modulated while powered down");

  AST_PD_RX_UPDATE: assert property (@(posedge clk_i) disable iff (rst_i)
    (!slave && pwr_q == LDT_PWR_DOWN && rx_done_i) |=>
      (burst_valid_flag_o && signal_out_first_o == $past(rx_word_i.sig_first)))
    else $error("powered-down master missed demod update");

  AST_PD_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (!slave && pwr_q == LDT_PWR_DOWN && !rx_done_i && !fs_edge) |=> $stable(burst_valid_flag_o))
    else $error("valid flag changed without a cause");

  AST_WAIT_THIRD: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwr_q == LDT_PWR_WAIT && pd_lvl && en && fs_edge && wait_cnt_q == MISS_LAST) |=> pwr_q == LDT_PWR_UP)
    else $error("master did not leave wait on third edge");

  AST_FIRST_WORD: assert property (@(posedge clk_i) disable iff (rst_i)
    (m_start && tx_start) |-> (tx_word.voice == voice_q && tx_word.sig_first == sync_q[1]))
    else $error("master burst payload not from frame edge");

  AST_SLAVE_DRIVES: assert property (@(posedge clk_i) disable iff (rst_i)
    (slave && en) |=> low_power_select_n_oe_o)
    else $error("slave stopped weak drive");

  AST_SLAVE_PD_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
    (slave && !pd_lvl) |-> !tx_start)
    else $error("slave transmitted while powered down");

  AST_REPLY_GAP: assert property (@(posedge clk_i) disable iff (rst_i)
    (slave && en && pd_lvl && rx_done_i) |=> (reply_arm_q && reply_cnt_q == REPLY_LAST))
    else $error("reply delay not armed");

  AST_SILENCE_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    (nob_tick && !rx_done_i) |=> !low_power_select_n_o)
    else $error("pin not pulled low after silence");

  AST_MISS_RESTART: assert property (@(posedge clk_i) disable iff (rst_i)
    (!slave && pwr_q == LDT_PWR_DOWN && rx_done_i) |=> miss_cnt_q == 2'h0)
    else $error("miss count not restarted");

endmodule : ldt_top
`default_nettype wire

// file: verification/ldt_remote.sv
// Far-side model: remote master burst completion and the shared power-down wire.
// Assumes the bench pulses send_i for one cycle per burst.
`timescale 1ns/1ps
`default_nettype none
module ldt_remote
  import ldt_pkg::*;
(
  input  wire logic       clk_i,       // core clock
  input  wire logic       rst_i,       // sync reset, high
  input  wire logic       send_i,      // bench asks for a burst
  input  wire ldt_burst_s word_i,      // payload to deliver
  input  wire logic       force_en_i,  // external pin drive on
  input  wire logic       force_val_i, // external pin level
  input  wire logic       weak_oe_i,   // block weak drive on
  input  wire logic       weak_val_i,  // block weak level
  output logic            rx_done_o,   // demod end pulse
  output ldt_burst_s      rx_word_o,   // demodulated word
  output logic            pin_o        // resolved pin level
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_done_o <= 1'b0;
      rx_word_o <= '0;
    end else begin
      rx_done_o <= send_i;
      // inverted every cycle outside the pulse, so only valid while rx_done_o is high
      rx_word_o <= send_i ? word_i : ~rx_word_o;
    end
  end
  assign pin_o = force_en_i ? force_val_i : (weak_oe_i ? weak_val_i : 1'b1);
endmodule : ldt_remote
`default_nettype wire

// file: verification/ldt_top_tb.sv
// Self-checking bench for the power-down sequencing and burst launch block.
// Assumes the far-side model resolves the power-down wire; small silence/frame counts.
`timescale 1ns/1ps
`default_nettype none
module ldt_top_tb
  import ldt_pkg::*;
;
  localparam int NB = 2000;
  localparam int FL = 1000;
  logic        clk_i, rst_i, psel, penable, pwrite, fs, send, f_en, f_val;
  logic [7:0]  paddr, vout, vword;
  logic [21:0] segs;
  logic        si1, si2, vwin;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, rx_done, pin, wo, woe, so1, so2, vflag, lvl, drv;
  ldt_burst_s  wrd, rxw;
  int          miscompares = 0, checks = 0, tmo = 0, drv_cyc = 0, seg_t = 0;

  ldt_top #(.NO_BURST_LEN(NB), .FRAME_LEN(FL)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .frame_sync_input_i(fs), .signal_in_first_i(si1),
    .signal_in_second_i(si2), .voice_word_i(vword), .voice_capture_window_i(vwin),
    .rx_done_i(rx_done), .rx_word_i(rxw), .low_power_select_n_i(pin),
    .low_power_select_n_o(wo), .low_power_select_n_oe_o(woe), .signal_out_first_o(so1),
    .signal_out_second_o(so2), .burst_valid_flag_o(vflag), .voice_out_o(vout),
    .line_level_o(lvl), .line_drive_o(drv));
  ldt_remote u_remote (
    .clk_i(clk_i), .rst_i(rst_i), .send_i(send), .word_i(wrd), .force_en_i(f_en),
    .force_val_i(f_val), .weak_oe_i(woe), .weak_val_i(wo), .rx_done_o(rx_done),
    .rx_word_o(rxw), .pin_o(pin));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (drv === 1'b1) drv_cyc <= drv_cyc + 1;
    tmo <= tmo + 1;
    if (tmo == 40000) begin
      miscompares++;
      end_of_test();
    end
  end
  // line decoder: one level sample in the middle of each half-cycle segment
  always @(posedge clk_i) begin
    if (drv !== 1'b1) begin
      seg_t <= 0;
    end else begin
      seg_t <= seg_t + 1;
      if (seg_t % HALF_CYC == HALF_CYC / 2) segs <= {segs[20:0], lvl};
    end
  end

  task automatic end_of_test();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic fsync();
    @(posedge clk_i) fs <= 1'b1;
    cyc(8);
    fs <= 1'b0;
    cyc(8);
  endtask : fsync
  task automatic burst(input ldt_burst_s w);
    @(posedge clk_i);
    send <= 1'b1; wrd <= w;
    @(posedge clk_i);
    send <= 1'b0;
  endtask : burst
  task automatic wait_drv(input logic v, input int lim, output int n);
    n = 0;
    while (drv !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_drv
  // one = toggle at the bit boundary, zero = flat double segment; mid-bit always toggles
  task automatic chk_line(input logic [9:0] exp);
    logic [9:0]  bits;
    logic [10:0] tog;
    for (int i = 0; i < 10; i++) begin
      bits[9 - i] = segs[21 - 2 * i] ^ segs[20 - 2 * i];
      tog[10 - i] = segs[20 - 2 * i] ^ segs[19 - 2 * i];
    end
    tog[0] = segs[1] ^ segs[0];
    chk({segs[21], tog}, {1'b1, 11'h7FF});
    chk(bits, exp);
  endtask : chk_line

  task automatic t_regs();
    logic [31:0] r;
    logic e;
    apb(1'b0, ADDR_CTRL, 32'h0, r, e); chk(r, {30'h0, CTRL_RESET});
    apb(1'b1, 8'h0C, 32'hFFFFFFFF, r, e); chk(e, 1'b1);
    apb(1'b0, 8'h0C, 32'h0, r, e); chk(r, 32'h0); chk(e, 1'b1);
    apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF, r, e); chk(e, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h1, r, e); chk(e, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h0, r, e); chk(r, 32'h1);
  endtask : t_regs
  task automatic t_master();
    logic [31:0] r;
    logic e;
    int d0;
    d0 = drv_cyc;
    repeat (3) fsync();
    chk(drv_cyc - d0, 0);
    burst({8'hA5, 1'b1, 1'b0});
    cyc(6);
    chk({vout, so1, so2, vflag}, {8'hA5, 3'b101});
    fsync(); fsync();
    burst({8'h3C, 1'b0, 1'b1});
    cyc(6);
    chk({vout, so1, so2, vflag}, {8'h3C, 3'b011});
    fsync(); fsync();
    chk(vflag, 1'b1);
    fsync();
    chk({so1, so2, vflag}, 3'b010);
    apb(1'b0, ADDR_STATUS, 32'h0, r, e);
    chk(r, 32'h0000_0008);
    si1 <= 1'b0; si2 <= 1'b1; vword <= 8'h96; vwin <= 1'b1;
    cyc(2);
    vwin <= 1'b0;
    cyc(2);
    f_val <= 1'b1;
    cyc(10);
    d0 = drv_cyc;
    fsync(); fsync();
    chk(drv_cyc - d0, 0);
    fsync();
    chk(drv_cyc > d0, 1'b1);
    cyc(1800);
    chk_line({8'h96, 1'b0, 1'b1});
  endtask : t_master
  task automatic t_slave();
    logic [31:0] r;
    logic e;
    int n, m, k, d0;
    si1 <= 1'b1; si2 <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h3, r, e);
    burst({8'h5A, 1'b0, 1'b1});
    wait_drv(1'b1, 2000, n);
    chk(n >= REPLY_CYC && n <= REPLY_CYC + 8, 1'b1);
    chk({lvl, vout, so1, so2}, {1'b1, 8'h5A, 2'b01});
    wait_drv(1'b0, 4000, m);
    chk(m >= 22 * HALF_CYC - 2 && m <= 22 * HALF_CYC + 2, 1'b1);
    chk_line({8'h96, 1'b1, 1'b0});
    wait_drv(1'b1, 4000, k);
    chk(n + m + k >= NB && n + m + k <= NB + 2 * FL + 50, 1'b1);
    chk({wo, woe, pin}, 3'b011);
    wait_drv(1'b0, 4000, m);
    wait_drv(1'b1, 4000, k);
    chk(m + k >= 2 * FL - 4 && m + k <= 2 * FL + 4, 1'b1);
    chk_line({8'h96, 1'b1, 1'b0});
    f_val <= 1'b0;
    cyc(2000);
    d0 = drv_cyc;
    burst({8'hC3, 1'b1, 1'b1});
    cyc(6);
    chk({vout, so1, so2}, {8'hC3, 2'b11});
    chk({wo, woe, pin}, 3'b110);
    cyc(1500);
    chk(drv_cyc - d0, 0);
  endtask : t_slave

  initial begin
    rst_i = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; fs = 1'b0; send = 1'b0; wrd = '0; f_en = 1'b1; f_val = 1'b0;
    si1 = 1'b1; si2 = 1'b0; vwin = 1'b0; vword = 8'h00;
    cyc(3);
    rst_i <= 1'b0;
    cyc(2);
    t_regs();
    t_master();
    t_slave();
    end_of_test();
  end
endmodule : ldt_top_tb
`default_nettype wire
